// ===== core/csb_unit.sv
// Purpose: Compare, conditional skip and conditional branch unit
// Assumes: Request fields are stable while i_valid is high
// Notes: o_busy holds off new requests during multi-cycle outcomes
`timescale 1ns/1ps
`default_nettype none
module csb_unit (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_valid,
	input  wire csb_pkg::csb_req_t i_req,
	input  wire logic [7:0]        i_flags,
	output logic [7:0]             o_flags,
	output logic                   o_flags_we,
	output logic                   o_done,
	output logic                   o_taken,
	output logic [csb_pkg::PC_W-1:0] o_pc_next,
	output logic                   o_busy
);
	function automatic logic [7:0] csb_sub_flags(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic       cin,
		input logic       keep_z,
		input logic [7:0] old
	);
		logic [7:0] r;
		logic [7:0] f;
		r = 8'(a - b - {7'h00, cin});
		f = old;
		f[csb_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		f[csb_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		f[csb_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		f[csb_pkg::FLAG_N] = r[7];
		f[csb_pkg::FLAG_S] = r[7] ^ f[csb_pkg::FLAG_V];
		// With carry, zero only sticks if it was already set
		f[csb_pkg::FLAG_Z] = (r == 8'h00) & (~keep_z | old[csb_pkg::FLAG_Z]);
		return f;
	endfunction : csb_sub_flags

	csb_pkg::csb_state_t state;
	logic [1:0]          cnt;

	wire accept = i_valid & (state == csb_pkg::ST_IDLE);
	csb_pkg::csb_op_t op;
	assign op = i_req.op;

	wire fc = i_flags[csb_pkg::FLAG_C];
	wire fz = i_flags[csb_pkg::FLAG_Z];
	wire fn = i_flags[csb_pkg::FLAG_N];
	wire fv = i_flags[csb_pkg::FLAG_V];
	wire fh = i_flags[csb_pkg::FLAG_H];
	wire ft = i_flags[csb_pkg::FLAG_T];
	wire fsel = i_flags[i_req.flag_sel];
	wire reg_bit = i_req.rr[i_req.bit_sel];
	wire io_bit = i_req.io_val[i_req.bit_sel];

	wire is_cmp = op inside {csb_pkg::compare_regs, csb_pkg::compare_regs_with_carry,
		csb_pkg::compare_immediate};

	wire skip_hit = (op == csb_pkg::compare_skip_equal && i_req.rd == i_req.rr)
		| (op == csb_pkg::skip_reg_bit_clear && !reg_bit)
		| (op == csb_pkg::skip_reg_bit_set && reg_bit)
		| (op == csb_pkg::skip_io_bit_clear && !io_bit)
		| (op == csb_pkg::skip_io_bit_set && io_bit);

	wire br_hit = (op == csb_pkg::branch_flag_set && fsel)
		| (op == csb_pkg::branch_flag_clear && !fsel)
		| (op == csb_pkg::branch_equal && fz)
		| (op == csb_pkg::branch_not_equal && !fz)
		| (op == csb_pkg::branch_carry_set && fc)
		| (op == csb_pkg::branch_lower && fc)
		| (op == csb_pkg::branch_carry_clear && !fc)
		| (op == csb_pkg::branch_same_or_higher && !fc)
		| (op == csb_pkg::branch_minus && fn)
		| (op == csb_pkg::branch_plus && !fn)
		| (op == csb_pkg::branch_greater_equal_signed && !(fn ^ fv))
		| (op == csb_pkg::branch_less_signed && (fn ^ fv))
		| (op == csb_pkg::branch_half_carry_set && fh)
		| (op == csb_pkg::branch_half_carry_clear && !fh)
		| (op == csb_pkg::branch_transfer_bit_set && ft)
		| (op == csb_pkg::branch_transfer_bit_clear && !ft)
		| (op == csb_pkg::branch_overflow_set && fv)
		| (op == csb_pkg::branch_overflow_clear && !fv);

	// Offset is a signed word displacement
	wire [csb_pkg::PC_W-1:0] ofs_ext = {{(csb_pkg::PC_W-csb_pkg::OFS_W){i_req.offset[6]}},
		i_req.offset};
	wire [csb_pkg::PC_W-1:0] br_target = i_req.pc + ofs_ext + csb_pkg::STEP_NEXT;
	wire [csb_pkg::PC_W-1:0] skip_step = i_req.next_two_word ? csb_pkg::STEP_SKIP_TWO
		: csb_pkg::STEP_SKIP_ONE;

	wire [csb_pkg::PC_W-1:0] next_pc = skip_hit ? i_req.pc + skip_step
		: br_hit ? br_target : i_req.pc + csb_pkg::STEP_NEXT;
	wire [1:0] next_cycles = skip_hit ? (i_req.next_two_word ? csb_pkg::CYC_SKIP_TWO
		: csb_pkg::CYC_SKIP_ONE) : br_hit ? csb_pkg::CYC_TAKEN : csb_pkg::CYC_PLAIN;

	// Compares write flags only, never a register result
	wire [7:0] cmp_b = (op == csb_pkg::compare_immediate) ? i_req.imm : i_req.rr;
	wire       cmp_c = (op == csb_pkg::compare_regs_with_carry) & fc;
	wire [7:0] next_flags = csb_sub_flags(i_req.rd, cmp_b, cmp_c,
		op == csb_pkg::compare_regs_with_carry, i_flags);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_flags <= csb_pkg::FLAGS_RESET;
			o_flags_we <= 1'b0;
		end else begin
			o_flags_we <= accept & is_cmp;
			if (accept & is_cmp) begin
				o_flags <= next_flags;
			end
		end
	end

	// Extra cycles are spent waiting so the fetch unit can discard work
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state <= csb_pkg::ST_IDLE;
			cnt <= 2'h0;
			o_done <= 1'b0;
			o_busy <= 1'b0;
			o_taken <= 1'b0;
			o_pc_next <= '0;
		end else begin
			case (state)
				csb_pkg::ST_IDLE: begin
					o_done <= accept && next_cycles == csb_pkg::CYC_PLAIN;
					if (accept) begin
						o_pc_next <= next_pc;
						o_taken <= skip_hit | br_hit;
						cnt <= 2'(next_cycles - 2'h2);
						if (next_cycles != csb_pkg::CYC_PLAIN) begin
							state <= csb_pkg::ST_BUSY;
							o_busy <= 1'b1;
						end
					end
				end
				csb_pkg::ST_BUSY: begin
					o_done <= (cnt == 2'h0);
					if (cnt == 2'h0) begin
						state <= csb_pkg::ST_IDLE;
						o_busy <= 1'b0;
					end else begin
						cnt <= 2'(cnt - 2'h1);
					end
				end
				default: begin
					state <= csb_pkg::ST_IDLE;
					o_busy <= 1'b0;
					o_done <= 1'b0;
				end
			endcase
		end
	end

	property p_skip_equal_two;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::compare_skip_equal && i_req.rd == i_req.rr
			&& i_req.next_two_word |=> o_busy && !o_done ##1 o_busy && !o_done
			##1 o_done && o_pc_next == 12'($past(i_req.pc, 3) + 12'h003);
	endproperty
	a_skip_equal_two: assert property (p_skip_equal_two) else $error("equal skip wrong");

	property p_compare_flags;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::compare_regs |=> o_done && o_flags_we
			&& o_flags[csb_pkg::FLAG_Z] == ($past(i_req.rd) == $past(i_req.rr))
			&& o_flags[csb_pkg::FLAG_C] == ($past(i_req.rd) < $past(i_req.rr));
	endproperty
	a_compare_flags: assert property (p_compare_flags) else $error("compare flags wrong");

	property p_skip_reg_clear;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::skip_reg_bit_clear && !reg_bit && !i_req.next_two_word
			|=> !o_done ##1 o_done && o_taken && !o_flags_we;
	endproperty
	a_skip_reg_clear: assert property (p_skip_reg_clear) else $error("reg skip wrong");

	property p_skip_io_set_miss;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::skip_io_bit_set && !io_bit
			|=> o_done && !o_taken && o_pc_next == 12'($past(i_req.pc) + 12'h001);
	endproperty
	a_skip_io_set_miss: assert property (p_skip_io_set_miss) else $error("io skip wrong");

	property p_flag_branch;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::branch_flag_set && fsel
			|=> o_busy ##1 o_done && o_taken && !o_busy;
	endproperty
	a_flag_branch: assert property (p_flag_branch) else $error("flag branch wrong");

	property p_signed_less;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::branch_less_signed |=> o_taken == ($past(fn) ^ $past(fv));
	endproperty
	a_signed_less: assert property (p_signed_less) else $error("signed branch wrong");

	property p_branch_target;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::branch_equal && fz |=> ##1 o_done
			&& o_pc_next == 12'($past(i_req.pc, 2) + 12'($signed($past(i_req.offset, 2)))
			+ 12'h001);
	endproperty
	a_branch_target: assert property (p_branch_target) else $error("target wrong");

	property p_not_taken_one;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		accept && op == csb_pkg::branch_overflow_set && !fv
			|=> o_done && !o_busy && !o_taken && !o_flags_we;
	endproperty
	a_not_taken_one: assert property (p_not_taken_one) else $error("miss timing wrong");
endmodule : csb_unit
`default_nettype wire

// ===== core/csb_pkg.sv
// Purpose: Shared types and constants of the compare, skip and branch unit
// Assumes: Word-addressed program counter, 8-bit status flag register
// Notes: Flag positions follow the core's status flag register layout
`default_nettype none
package csb_pkg;
	localparam int PC_W  = 12;
	localparam int OFS_W = 7;

	// Status flag register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// Cycle counts per outcome
	localparam logic [1:0] CYC_PLAIN    = 2'h1;
	localparam logic [1:0] CYC_TAKEN    = 2'h2;
	localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO = 2'h3;

	// Program counter steps in words
	localparam logic [PC_W-1:0] STEP_NEXT     = 12'h001;
	localparam logic [PC_W-1:0] STEP_SKIP_ONE = 12'h002;
	localparam logic [PC_W-1:0] STEP_SKIP_TWO = 12'h003;

	typedef enum logic [4:0] {
		compare_skip_equal,
		compare_regs,
		compare_regs_with_carry,
		compare_immediate,
		skip_reg_bit_clear,
		skip_reg_bit_set,
		skip_io_bit_clear,
		skip_io_bit_set,
		branch_flag_set,
		branch_flag_clear,
		branch_equal,
		branch_not_equal,
		branch_carry_set,
		branch_carry_clear,
		branch_same_or_higher,
		branch_lower,
		branch_minus,
		branch_plus,
		branch_greater_equal_signed,
		branch_less_signed,
		branch_half_carry_set,
		branch_half_carry_clear,
		branch_transfer_bit_set,
		branch_transfer_bit_clear,
		branch_overflow_set,
		branch_overflow_clear
	} csb_op_t;

	typedef enum {ST_IDLE, ST_BUSY} csb_state_t;

	typedef struct packed {
		csb_op_t          op;
		logic [7:0]       rd;
		logic [7:0]       rr;
		logic [7:0]       imm;
		logic [2:0]       bit_sel;
		logic [7:0]       io_val;
		logic [2:0]       flag_sel;
		logic [OFS_W-1:0] offset;
		logic [PC_W-1:0]  pc;
		logic             next_two_word;
	} csb_req_t;
endpackage : csb_pkg
`default_nettype wire

// ===== bench/csb_unit_tb.sv
// Purpose: Self-checking bench of the compare, skip and branch unit
// Assumes: Branch ops are declared in the package in documented order
// Notes: i_valid stays high between tasks, so requests run back to back
`timescale 1ns/1ps
`default_nettype none
module csb_unit_tb;
	logic              i_ref_clk = 1'b0;
	logic              i_rst_n   = 1'b0;
	logic              i_valid   = 1'b0;
	csb_pkg::csb_req_t req       = '0;
	logic [7:0]        flags     = 8'h00;
	logic [7:0]        o_flags;
	logic              o_flags_we;
	logic              o_done;
	logic              o_taken;
	logic [11:0]       o_pc_next;
	logic              o_busy;
	int                miscompares = 0;
	int                cmp_count   = 0;

	always #20 i_ref_clk = ~i_ref_clk;

	csb_unit DUT (
		.i_ref_clk  (i_ref_clk),
		.i_rst_n    (i_rst_n),
		.i_valid    (i_valid),
		.i_req      (req),
		.i_flags    (flags),
		.o_flags    (o_flags),
		.o_flags_we (o_flags_we),
		.o_done     (o_done),
		.o_taken    (o_taken),
		.o_pc_next  (o_pc_next),
		.o_busy     (o_busy)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic results;
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// Entered at a falling edge; leaves valid high so the next call follows at once
	task automatic go(input logic et, input logic [1:0] ec, input logic [11:0] epc, input logic we);
		int n;
		int nb;
		n = 0;
		nb = 0;
		i_valid = 1'b1;
		do begin
			@(negedge i_ref_clk);
			n++;
			if (o_busy === 1'b1)
				nb++;
		end while (o_done !== 1'b1 && n < 8);
		chk(16'(n), {14'h0, ec}, "cycles");
		chk(16'(nb), 16'(ec - 2'h1), "busy cycles");
		chk({15'h0, o_taken}, {15'h0, et}, "taken");
		chk({4'h0, o_pc_next}, {4'h0, epc}, "next pc");
		chk({15'h0, o_flags_we}, {15'h0, we}, "flag write");
	endtask : go

	task automatic zeros;
		chk({o_flags, 4'h0, o_flags_we, o_done, o_taken, o_busy}, 16'h0000, "reset out");
		chk({4'h0, o_pc_next}, 16'h0000, "reset pc");
	endtask : zeros

	// Operand not named by the op gets the inverse, so a wrong operand select shows
	task automatic cmp1(input csb_pkg::csb_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] fl, input logic [7:0] ef);
		req.op = op;
		req.rd = a;
		req.rr = (op == csb_pkg::compare_immediate) ? ~b : b;
		req.imm = (op == csb_pkg::compare_immediate) ? b : ~b;
		req.pc = 12'hfff;
		flags = fl;
		go(1'b0, 2'h1, 12'h000, 1'b1);
		chk({8'h00, o_flags}, {8'h00, ef}, "flags");
	endtask : cmp1

	task automatic t_compare;
		cmp1(csb_pkg::compare_regs, 8'h10, 8'h28, 8'hc0, 8'hf5);
		cmp1(csb_pkg::compare_regs, 8'h80, 8'h01, 8'h3f, 8'h38);
		cmp1(csb_pkg::compare_immediate, 8'h3f, 8'h3f, 8'h00, 8'h02);
		// Carry compare keeps a clear zero flag clear even on a zero result
		cmp1(csb_pkg::compare_regs_with_carry, 8'h05, 8'h04, 8'h01, 8'h00);
		cmp1(csb_pkg::compare_regs_with_carry, 8'h05, 8'h04, 8'h03, 8'h02);
	endtask : t_compare

	task automatic sk(input logic s);
		logic [1:0] st;
		st = s ? 2'h2 + {1'b0, req.next_two_word} : 2'h1;
		go(s, st, req.pc + {10'h000, st}, 1'b0);
	endtask : sk

	task automatic t_skip;
		req.pc = 12'hffe;
		req.io_val = 8'h69;
		for (int t = 0; t < 2; t++) begin
			req.next_two_word = t[0];
			req.op = csb_pkg::compare_skip_equal;
			req.rd = 8'h5a;
			req.rr = 8'h5a;
			sk(1'b1);
			req.rr = 8'h5b;
			sk(1'b0);
			req.rr = 8'h96;
			for (int b = 0; b < 8; b++) begin
				req.bit_sel = 3'(b);
				req.op = csb_pkg::skip_reg_bit_clear;
				sk(~req.rr[b]);
				req.op = csb_pkg::skip_reg_bit_set;
				sk(req.rr[b]);
				req.op = csb_pkg::skip_io_bit_clear;
				sk(~req.io_val[b]);
				req.op = csb_pkg::skip_io_bit_set;
				sk(req.io_val[b]);
			end
		end
	endtask : t_skip

	// Index j runs over the branch ops in package order
	function automatic logic cond(int j, logic [7:0] f, logic [2:0] s);
		logic v;
		case (j)
			0, 1: v = f[s];
			2, 3: v = f[1];
			4, 5, 6, 7: v = f[0];
			8, 9: v = f[2];
			10, 11: v = f[2] ^ f[3];
			12, 13: v = f[5];
			14, 15: v = f[6];
			default: v = f[3];
		endcase
		return (j inside {6, 7, 10, 11}) ? (v == j[0]) : (v != j[0]);
	endfunction : cond

	task automatic t_branch;
		logic [7:0] pat[7] = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h09, 8'h0c, 8'h24};
		logic       c;
		req.pc = 12'h020;
		for (int p = 0; p < 7; p++) begin
			for (int j = 0; j < 18; j++) begin
				for (int s = 0; s < 8; s++) begin
					req.op = csb_pkg::csb_op_t'(j + int'(csb_pkg::branch_flag_set));
					req.flag_sel = 3'(s);
					req.offset = s[0] ? 7'h40 : 7'h3f;
					flags = pat[p];
					c = cond(j, pat[p], 3'(s));
					go(c, c ? 2'h2 : 2'h1, c ? req.pc + {{5{req.offset[6]}}, req.offset} + 12'h001
						: req.pc + 12'h001, 1'b0);
				end
			end
		end
	endtask : t_branch

	// Reset in the middle of a taken branch must clear every output
	task automatic t_reset;
		req.op = csb_pkg::branch_flag_set;
		req.flag_sel = 3'h0;
		flags = 8'h01;
		@(negedge i_ref_clk);
		chk({15'h0, o_busy}, 16'h0001, "busy before reset");
		i_rst_n = 1'b0;
		i_valid = 1'b0;
		@(negedge i_ref_clk);
		zeros();
		i_rst_n = 1'b1;
		cmp1(csb_pkg::compare_regs, 8'h00, 8'h01, 8'h00, 8'h35);
	endtask : t_reset

	initial begin
		#2000000;
		miscompares++;
		results();
	end

	initial begin
		repeat (16) @(negedge i_ref_clk);
		zeros();
		i_rst_n = 1'b1;
		t_compare();
		t_skip();
		t_branch();
		t_reset();
		results();
	end
endmodule : csb_unit_tb
`default_nettype wire
